// File: common/alt_map.svh
`ifndef ALT_MAP_SVH
`define ALT_MAP_SVH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define ALT_OP_TIMER_SIX  10'h250
`define ALT_OP_POINTER_X  10'h252
`define ALT_OP_POINTER_Y  10'h253
`define ALT_OP_POINTER_Z  10'h053

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define ALT_INSN_W        10
`define ALT_ACC_W         4
`define ALT_Z_W           2
`define ALT_ACC_RST       4'h0
`define ALT_ZERO_HI       2'h0

`endif

// File: common/alt_pkg.sv
`include "alt_map.svh"

package alt_pkg;

    typedef enum logic [2:0] {
        ALT_OP_NONE   = 3'h0,
        ALT_OP_TIMER  = 3'h1,
        ALT_OP_X      = 3'h3,
        ALT_OP_Y      = 3'h2,
        ALT_OP_Z      = 3'h6
    } alt_op_t;

    typedef struct packed {
        logic [`ALT_ACC_W-1:0] timer_control_six;
        logic [`ALT_ACC_W-1:0] pointer_x;
        logic [`ALT_ACC_W-1:0] pointer_y;
        logic [`ALT_Z_W-1:0]   pointer_z;
    } alt_src_t;

    typedef struct packed {
        logic load_acc_from_timer_ctl_six;
        logic load_acc_from_pointer_x;
        logic load_acc_from_pointer_y;
        logic load_acc_from_pointer_z;
    } alt_hit_t;

endpackage : alt_pkg

// File: rtl/alt_decode.sv
`timescale 1ns/1ps
`include "alt_map.svh"

module alt_decode (
    input  wire logic [`ALT_INSN_W-1:0] i_insn,
    output alt_pkg::alt_op_t            o_op
);

    // ----------------------------------------------------------------------
    // Opcode match
    // ----------------------------------------------------------------------
    always_comb begin
        case (i_insn)
            `ALT_OP_TIMER_SIX: o_op = alt_pkg::ALT_OP_TIMER;
            `ALT_OP_POINTER_X: o_op = alt_pkg::ALT_OP_X;
            `ALT_OP_POINTER_Y: o_op = alt_pkg::ALT_OP_Y;
            `ALT_OP_POINTER_Z: o_op = alt_pkg::ALT_OP_Z;
            default:           o_op = alt_pkg::ALT_OP_NONE;
        endcase
    end

endmodule : alt_decode

// File: rtl/alt_top.sv
`timescale 1ns/1ps
`include "alt_map.svh"

module alt_top (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_reset,
    input  wire logic                  i_insn_valid,
    input  wire logic [`ALT_INSN_W-1:0] i_insn,
    input  wire alt_pkg::alt_src_t     i_src,
    output logic                       o_acc_we,
    output logic [`ALT_ACC_W-1:0]      o_acc_data,
    output alt_pkg::alt_hit_t          o_hit,
    output logic                       o_timer_op,
    output logic                       o_skip,
    output logic                       o_carry_we
);

    // ----------------------------------------------------------------------
    // Local sizes
    // ----------------------------------------------------------------------

    localparam int                 ACC_W   = `ALT_ACC_W;
    localparam int                 Z_W     = `ALT_Z_W;
    localparam int                 HIT_W   = $bits(alt_pkg::alt_hit_t);
    localparam logic [ACC_W-1:0]   ACC_RST = `ALT_ACC_RST;

    // ----------------------------------------------------------------------
    // Internal signals
    // ----------------------------------------------------------------------

    alt_pkg::alt_op_t              op;
    logic                          take;
    logic                          is_timer;
    logic                          is_x;
    logic                          is_y;
    logic                          is_z;
    logic [ACC_W-1:0]              z_ext;
    logic [ACC_W-1:0]              acc_d;
    logic [HIT_W-1:0]              hit_d;
    logic                          acc_we_d;
    logic                          timer_op_d;

    // ----------------------------------------------------------------------
    // Opcode decode
    // ----------------------------------------------------------------------

    // Pure compare logic, so the answer is ready in the same cycle as the word
    alt_decode u_dec (
        .i_insn (i_insn),
        .o_op   (op)
    );

    // ----------------------------------------------------------------------
    // One-hot view of the decoded load
    // ----------------------------------------------------------------------

    always_comb begin
        is_timer = 1'b0;
        is_x     = 1'b0;
        is_y     = 1'b0;
        is_z     = 1'b0;
        case (op)
            alt_pkg::ALT_OP_TIMER: begin
                is_timer = 1'b1;
            end
            alt_pkg::ALT_OP_X: begin
                is_x = 1'b1;
            end
            alt_pkg::ALT_OP_Y: begin
                is_y = 1'b1;
            end
            alt_pkg::ALT_OP_Z: begin
                is_z = 1'b1;
            end
            default: begin
                is_timer = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------------
    // Take condition
    // ----------------------------------------------------------------------

    // Every load is a single word, so there is no second fetch to wait for
    assign take = i_insn_valid && (op != alt_pkg::ALT_OP_NONE);

    // ----------------------------------------------------------------------
    // Source shaping
    // ----------------------------------------------------------------------

    // Z is narrower than the accumulator; the upper bits are forced low
    assign z_ext = {`ALT_ZERO_HI, i_src.pointer_z};

    // ----------------------------------------------------------------------
    // Per-bit source select
    // ----------------------------------------------------------------------

    // Sources are only read here, so the timer control register is never disturbed
    for (genvar b = 0; b < ACC_W; b++) begin : g_acc_bit
        assign acc_d[b] = (is_timer & i_src.timer_control_six[b])
                        | (is_x     & i_src.pointer_x[b])
                        | (is_y     & i_src.pointer_y[b])
                        | (is_z     & z_ext[b]);
    end

    // ----------------------------------------------------------------------
    // Next values of the strobes
    // ----------------------------------------------------------------------

    assign acc_we_d   = take;
    assign timer_op_d = i_insn_valid && is_timer;

    // Field order of the hit struct is timer, x, y, z from the top bit down
    assign hit_d = {i_insn_valid && is_timer,
                    i_insn_valid && is_x,
                    i_insn_valid && is_y,
                    i_insn_valid && is_z};

    // ----------------------------------------------------------------------
    // Accumulator write strobe
    // ----------------------------------------------------------------------

    // One pulse per load: the write finishes in the cycle after the word
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_acc_we <= 1'b0;
        end else begin
            o_acc_we <= acc_we_d;
        end
    end

    // ----------------------------------------------------------------------
    // Accumulator write data
    // ----------------------------------------------------------------------

    // Data follows the decode even without valid; only the strobe qualifies it
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_acc_data <= ACC_RST;
        end else begin
            o_acc_data <= acc_d;
        end
    end

    // ----------------------------------------------------------------------
    // Load flags
    // ----------------------------------------------------------------------

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_hit <= '0;
        end else begin
            o_hit <= alt_pkg::alt_hit_t'(hit_d);
        end
    end

    // ----------------------------------------------------------------------
    // Timer class flag
    // ----------------------------------------------------------------------

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_timer_op <= 1'b0;
        end else begin
            o_timer_op <= timer_op_d;
        end
    end

    // ----------------------------------------------------------------------
    // Skip request
    // ----------------------------------------------------------------------

    // Held registered so every output leaves a flop, even this constant one
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_skip <= 1'b0;
        end else begin
            o_skip <= 1'b0;
        end
    end

    // ----------------------------------------------------------------------
    // Carry write
    // ----------------------------------------------------------------------

    // These loads never touch the carry flag
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_carry_we <= 1'b0;
        end else begin
            o_carry_we <= 1'b0;
        end
    end

endmodule : alt_top

// File: sim/alt_src_model.sv
`timescale 1ns/1ps
module alt_src_model (
    input  wire alt_pkg::alt_src_t i_val,
    output alt_pkg::alt_src_t      o_src
);
    assign o_src = i_val;
endmodule : alt_src_model

// File: sim/alt_sva.sv
`timescale 1ns/1ps
module alt_sva (
    input wire logic i_core_clk, i_reset, i_insn_valid,
    input wire logic [9:0] i_insn,
    input wire alt_pkg::alt_src_t i_src,
    input wire logic o_acc_we, o_timer_op, o_skip, o_carry_we,
    input wire logic [3:0] o_acc_data,
    input wire alt_pkg::alt_hit_t o_hit
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    sequence s_op(op); i_insn_valid && i_insn == op; endsequence
    AST_TMR: assert property (s_op(10'h250) |=> o_acc_we && o_acc_data ==
        $past(i_src.timer_control_six)) else $error("timer");
    AST_TOP: assert property (o_timer_op |-> $past(i_insn == 10'h250)) else $error("op");
    AST_X: assert property (s_op(10'h252) |=> o_hit.load_acc_from_pointer_x &&
        o_acc_data == $past(i_src.pointer_x)) else $error("x");
    AST_Y: assert property (s_op(10'h253) |=> o_hit.load_acc_from_pointer_y &&
        o_acc_data == $past(i_src.pointer_y)) else $error("y");
    AST_Z: assert property (s_op(10'h053) |=> o_acc_we &&
        o_acc_data == {2'h0, $past(i_src.pointer_z)}) else $error("z");
    AST_ONE: assert property (!o_skip && !o_carry_we &&
        (o_acc_we -> $past(i_insn_valid))) else $error("one");
endmodule : alt_sva
bind alt_top alt_sva u_sva (.*);

// File: sim/alt_top_tb.sv
`timescale 1ns/1ps
module alt_top_tb;
    logic clk = 0, rst = 1, vld = 0, we, tmr, skp, cwe;
    logic [9:0] insn = 10'h000;
    logic [31:0] sd = 32'h2E21;
    logic [3:0] dat;
    logic [11:0] e, q[$];
    alt_pkg::alt_src_t val = '0, src;
    alt_pkg::alt_hit_t hit;
    int err_total = 0, n_checks = 0;
    // A near miss opcode makes sure the decode is exact
    logic [9:0] ops [5] = '{10'h250, 10'h252, 10'h253, 10'h053, 10'h251};
    initial forever #4 clk = ~clk;
    alt_src_model u_src (.i_val(val), .o_src(src));
    alt_top u_dut (.i_core_clk(clk), .i_reset(rst), .i_insn_valid(vld), .i_insn(insn),
        .i_src(src), .o_acc_we(we), .o_acc_data(dat), .o_hit(hit), .o_timer_op(tmr),
        .o_skip(skp), .o_carry_we(cwe));
    function automatic logic [11:0] exp_of(logic v, logic [9:0] o, alt_pkg::alt_src_t s);
        logic [3:0] h;
        h = {o == 10'h250, o == 10'h252, o == 10'h253, o == 10'h053} & {4{v}};
        return {|h, h, h[3], 2'h0, h[3] ? s.timer_control_six : h[2] ? s.pointer_x :
            h[1] ? s.pointer_y : {2'h0, s.pointer_z}};
    endfunction : exp_of
    task automatic cmp(string nm, logic [11:0] x, logic [11:0] s);
        n_checks++;
        if (x !== s) begin
            err_total++;
            $display("mismatch %s exp %h got %h", nm, x, s);
        end
    endtask : cmp
    function automatic logic [31:0] next_rand(logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : next_rand
    task final_report;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    // Data is only meaningful under the strobe, so it is masked otherwise
    always @(negedge clk) if (q.size() > 1) begin
        e = q.pop_front();
        cmp("acc", e & {8'hFF, {4{e[11]}}}, {we, hit, tmr, skp, cwe, dat & {4{e[11]}}});
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        for (int i = 0; i < 500; i++) begin
            @(posedge clk);
            sd = next_rand(sd);
            vld <= sd[31:30] != 0 && i < 499;
            insn <= ops[sd[7:0] % 5];
            val <= sd[29:16];
            q.push_back(exp_of(sd[31:30] != 0 && i < 499, ops[sd[7:0] % 5], sd[29:16]));
        end
        repeat (2) @(posedge clk);
        final_report;
    end
    initial begin
        #40000;
        err_total++;
        final_report;
    end
endmodule : alt_top_tb
